// ---- src/tpd_dialer.sv ----
// tone and pulse dialer control with wishbone register access
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps

module tpd_dialer
    import tpd_pkg::*;
#(
    parameter int         SLOW_DIV        = SLOW_DIV_CYC,
    parameter logic [0:0] TONE_DUR_OPTION = 1'b1
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [17:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             irq_o,
    output logic             dial_pulse_out_o,
    output logic             tx_mute_out_n_o,
    output logic             rx_mute_out_n_o,
    output logic             hold_line_out_o,
    output logic             handsfree_out_o,
    output logic             tone_active_o,
    output logic             row_tone_enable_o,
    output logic             col_tone_enable_o,
    output logic      [3:0]  digit_code_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [3:0]  dial_config_ff;
    logic [3:0]  pause_time_sel_ff;
    logic [3:0]  flash_time_sel_ff;
    logic [3:0]  line_ctrl_ff;
    logic [3:0]  interdigit_pause_sel_ff;
    logic [3:0]  tone_ctrl_ff;
    logic [3:0]  digit_code_ff;
    logic [3:0]  hook_ctrl_ff;
    logic [3:0]  pin_sel_ff;
    logic        dialer_irq_mask_ff;
    logic        dialer_irq_flag_ff;
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic [15:0] div_ff;
    logic        slow_tick_ff;
    tpd_state_e  state_ff;
    logic [19:0] tmr_ff;
    logic [3:0]  pulse_cnt_ff;
    logic [3:0]  pulse_goal_ff;
    logic        done_ff;

    logic [15:0] idx;
    logic        wr_go;
    logic        idle;
    logic        offhook;
    logic        start_digit;
    logic        start_pause;
    logic        start_flash;
    logic        dialing;
    logic [31:0] nxt_dat;
    logic [19:0] period_tk;
    logic [19:0] make_tk;
    logic [19:0] tone_tk;

    assign idx     = adr_i[17:2];
    assign wr_go   = cyc_i && stb_i && we_i && ack_ff && sel_i[0];
    assign idle    = (state_ff == ST_IDLE);
    assign offhook = hook_ctrl_ff[B_OFFHOOK];
    assign dialing = (state_ff == ST_BREAK) || (state_ff == ST_MAKE) || (state_ff == ST_TONE);

    // commands; busy block ignores new ones so only going on-hook cuts a running digit short
    assign start_digit = wr_go && (idx == IDX_DIGIT) && idle && offhook;
    assign start_pause = wr_go && (idx == IDX_LINE_CTRL) && idle && dat_i[B_PAUSE];
    assign start_flash = wr_go && (idx == IDX_LINE_CTRL) && idle && !dat_i[B_PAUSE]
                         && dat_i[B_FLASH];

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone classic slave: one wait cycle, ack for one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= cyc_i && stb_i && !ack_ff;
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        nxt_dat = 32'h0000_0000;
        if (idx == IDX_DIAL_CFG)
            nxt_dat[3:0] = dial_config_ff;
        else if (idx == IDX_PAUSE_SEL)
            nxt_dat[3:0] = pause_time_sel_ff;
        else if (idx == IDX_FLASH_SEL)
            nxt_dat[3:0] = flash_time_sel_ff;
        else if (idx == IDX_LINE_CTRL)
            nxt_dat[3:0] = line_ctrl_ff;
        else if (idx == IDX_GAP_SEL)
            nxt_dat[3:0] = interdigit_pause_sel_ff;
        else if (idx == IDX_TONE_CTRL)
            nxt_dat[3:0] = tone_ctrl_ff;
        else if (idx == IDX_DIGIT)
            nxt_dat[3:0] = digit_code_ff;
        else if (idx == IDX_HOOK_CTRL)
            nxt_dat[3:0] = hook_ctrl_ff;
        else if (idx == IDX_PIN_SEL)
            nxt_dat[3:0] = pin_sel_ff;
        else if (idx == IDX_IRQ_MASK)
            nxt_dat[B_IRQ] = dialer_irq_mask_ff;
        else if (idx == IDX_IRQ_STATUS)
            nxt_dat[B_IRQ] = dialer_irq_flag_ff;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_ff <= 32'h0000_0000;
        else if (cyc_i && stb_i && !ack_ff)
            dat_ff <= nxt_dat;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // plain settings registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dial_config_ff          <= RST_DIAL_CFG;
            pause_time_sel_ff       <= RST_PAUSE_SEL;
            flash_time_sel_ff       <= RST_FLASH_SEL;
            interdigit_pause_sel_ff <= RST_GAP_SEL;
            tone_ctrl_ff            <= RST_TONE_CTRL;
            digit_code_ff           <= RST_ZERO;
            hook_ctrl_ff            <= RST_ZERO;
            pin_sel_ff              <= RST_ZERO;
            dialer_irq_mask_ff      <= 1'b0;
        end
        else if (wr_go)
        begin
            if (idx == IDX_DIAL_CFG)
                dial_config_ff <= dat_i[3:0] & 4'hb;
            else if (idx == IDX_PAUSE_SEL)
                pause_time_sel_ff <= dat_i[3:0];
            else if (idx == IDX_FLASH_SEL)
                flash_time_sel_ff <= dat_i[3:0];
            else if (idx == IDX_GAP_SEL)
                interdigit_pause_sel_ff <= dat_i[3:0];
            else if (idx == IDX_TONE_CTRL)
            begin
                tone_ctrl_ff <= dat_i[3:0];
                // option absent: duration bit stays zero
                tone_ctrl_ff[B_TONE_DUR] <= dat_i[B_TONE_DUR] & TONE_DUR_OPTION[0];
            end
            else if (idx == IDX_DIGIT && idle)
                digit_code_ff <= dat_i[3:0];
            else if (idx == IDX_HOOK_CTRL)
                hook_ctrl_ff <= dat_i[3:0] & 4'hb;
            else if (idx == IDX_PIN_SEL)
                pin_sel_ff <= dat_i[3:0];
            else if (idx == IDX_IRQ_MASK)
                dialer_irq_mask_ff <= dat_i[B_IRQ];
        end
    end

    // line function bits: hold and handsfree are levels, pause and flash self-clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            line_ctrl_ff <= RST_ZERO;
        else if (done_ff && state_ff == ST_IDLE)
            line_ctrl_ff[1:0] <= 2'b00;
        else if (wr_go && idx == IDX_LINE_CTRL)
        begin
            line_ctrl_ff[B_HOLD]      <= dat_i[B_HOLD];
            line_ctrl_ff[B_HANDSFREE] <= dat_i[B_HANDSFREE];
            line_ctrl_ff[B_PAUSE]     <= start_pause ? 1'b1 : line_ctrl_ff[B_PAUSE];
            line_ctrl_ff[B_FLASH]     <= start_flash ? 1'b1 : line_ctrl_ff[B_FLASH];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt flag: set beats a simultaneous write-one clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dialer_irq_flag_ff <= 1'b0;
        else if (done_ff)
            dialer_irq_flag_ff <= 1'b1;
        else if (wr_go && idx == IDX_IRQ_STATUS && dat_i[B_IRQ])
            dialer_irq_flag_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // slow time base, one-cycle enable at the slow oscillator rate
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_ff       <= 16'h0000;
            slow_tick_ff <= 1'b0;
        end
        else if (div_ff >= 16'(SLOW_DIV - 1))
        begin
            div_ff       <= 16'h0000;
            slow_tick_ff <= 1'b1;
        end
        else
        begin
            div_ff       <= div_ff + 16'h0001;
            slow_tick_ff <= 1'b0;
        end
    end

    // pulse shape from rate and ratio bits; make time halves at the fast rate, share unchanged
    assign period_tk = dial_config_ff[B_PULSE_RATE] ? 20'(PER20_TK) : 20'(PER10_TK);
    assign make_tk   = dial_config_ff[B_MAKE_RATIO]
                     ? 20'(PER20_TK * 2 * MAKE_33_PERMIL / 1000) >> dial_config_ff[B_PULSE_RATE]
                     : 20'(PER20_TK * 2 * MAKE_40_PERMIL / 1000) >> dial_config_ff[B_PULSE_RATE];
    assign tone_tk   = tone_ctrl_ff[B_TONE_DUR] ? 20'(TONE_SHORT_TK) : 20'(TONE_LONG_TK);

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer: digit, inter-digit gap, pause and flash, timer in slow ticks
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff      <= ST_IDLE;
            tmr_ff        <= 20'h00000;
            pulse_cnt_ff  <= 4'h0;
            pulse_goal_ff <= 4'h0;
            done_ff       <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            if (slow_tick_ff && tmr_ff != 20'h00000)
                tmr_ff <= tmr_ff - 20'h00001;
            case (state_ff)
                ST_IDLE:
                begin
                    if (start_digit && dial_config_ff[B_DIAL_MODE])
                    begin
                        state_ff      <= ST_BREAK;
                        tmr_ff        <= period_tk - make_tk;
                        pulse_cnt_ff  <= 4'h1;
                        // digit zero sends ten pulses
                        pulse_goal_ff <= (dat_i[3:0] == 4'h0) ? ZERO_DIGIT_PULSES : dat_i[3:0];
                    end
                    else if (start_digit)
                    begin
                        state_ff <= ST_TONE;
                        tmr_ff   <= tone_tk;
                    end
                    else if (start_pause)
                    begin
                        state_ff <= ST_TIMED;
                        tmr_ff   <= 20'(PAUSE_STEP_TK) * 20'(dat_i[B_PAUSE] ?
                                    ((pause_time_sel_ff == 4'h0) ? 4'h1 : pause_time_sel_ff)
                                    : 4'h1);
                    end
                    else if (start_flash)
                    begin
                        state_ff <= ST_TIMED;
                        tmr_ff   <= 20'(SEL_STEP_TK) *
                                    20'((flash_time_sel_ff == 4'h0) ? 4'h1 : flash_time_sel_ff);
                    end
                end
                ST_BREAK:
                begin
                    if (tmr_ff == 20'h00000)
                    begin
                        state_ff <= ST_MAKE;
                        tmr_ff   <= make_tk;
                    end
                end
                ST_MAKE:
                begin
                    if (tmr_ff == 20'h00000 && pulse_cnt_ff == pulse_goal_ff)
                    begin
                        state_ff <= ST_GAP;
                        tmr_ff   <= 20'(SEL_STEP_TK) * 20'((interdigit_pause_sel_ff == 4'h0)
                                    ? 4'h1 : interdigit_pause_sel_ff);
                    end
                    else if (tmr_ff == 20'h00000)
                    begin
                        state_ff     <= ST_BREAK;
                        tmr_ff       <= period_tk - make_tk;
                        pulse_cnt_ff <= pulse_cnt_ff + 4'h1;
                    end
                end
                ST_TONE:
                begin
                    // continuous tone bit stretches past the least duration
                    if (tmr_ff == 20'h00000 && !tone_ctrl_ff[B_CONT_TONE])
                    begin
                        state_ff <= ST_GAP;
                        tmr_ff   <= 20'(TONE_GAP_TK);
                    end
                end
                ST_GAP, ST_TIMED:
                begin
                    if (tmr_ff == 20'h00000)
                    begin
                        state_ff <= ST_IDLE;
                        done_ff  <= 1'b1;
                    end
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
            // going on-hook abandons a digit without an interrupt
            if (!offhook && state_ff != ST_IDLE && state_ff != ST_TIMED)
                state_ff <= ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // line side outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dial_pulse_out_o  <= 1'b0;
            tx_mute_out_n_o   <= 1'b1;
            rx_mute_out_n_o   <= 1'b1;
            hold_line_out_o   <= 1'b0;
            handsfree_out_o   <= 1'b0;
            tone_active_o     <= 1'b0;
            row_tone_enable_o <= 1'b0;
            col_tone_enable_o <= 1'b0;
            digit_code_o      <= 4'h0;
        end
        else
        begin
            // line opens during each break and during a flash
            dial_pulse_out_o  <= offhook && state_ff != ST_BREAK
                                 && !(state_ff == ST_TIMED && line_ctrl_ff[B_FLASH]);
            tx_mute_out_n_o   <= !(pin_sel_ff[B_SEL_TX_MUTE] && hook_ctrl_ff[B_TX_MUTE_EN]
                                   && dialing);
            rx_mute_out_n_o   <= !(pin_sel_ff[B_SEL_RX_MUTE] && hook_ctrl_ff[B_RX_MUTE_EN]
                                   && dialing);
            hold_line_out_o   <= pin_sel_ff[B_SEL_HOLD] && line_ctrl_ff[B_HOLD];
            handsfree_out_o   <= pin_sel_ff[B_SEL_HFREE] && line_ctrl_ff[B_HANDSFREE];
            tone_active_o     <= (state_ff == ST_TONE);
            row_tone_enable_o <= tone_ctrl_ff[B_ROW_TONE];
            col_tone_enable_o <= tone_ctrl_ff[B_COL_TONE];
            digit_code_o      <= digit_code_ff;
        end
    end

    assign dat_o = dat_ff;
    assign ack_o = ack_ff;
    assign irq_o = dialer_irq_flag_ff && dialer_irq_mask_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    dur_option_a: assert property (!TONE_DUR_OPTION[0] |-> !tone_ctrl_ff[B_TONE_DUR])
        else $error("duration bit set without option");
    reset_mode_a: assert property ($past(rst_i) |-> !dial_config_ff[B_DIAL_MODE]
        && interdigit_pause_sel_ff == RST_GAP_SEL && flash_time_sel_ff == RST_FLASH_SEL)
        else $error("reset defaults wrong");
    offhook_line_a: assert property (idle && !done_ff && offhook && $past(idle)
        |=> dial_pulse_out_o || !$past(offhook, 1) || !idle)
        else $error("line not connected while off-hook");
    break_line_a: assert property (state_ff == ST_BREAK ##1 state_ff == ST_BREAK
        |-> !dial_pulse_out_o)
        else $error("line not opened during break");
    pulse_count_a: assert property (state_ff == ST_GAP && $past(state_ff) == ST_MAKE
        |-> pulse_cnt_ff == pulse_goal_ff)
        else $error("wrong pulse count");
    mute_dial_a: assert property (state_ff == ST_BREAK && pin_sel_ff[B_SEL_TX_MUTE]
        && hook_ctrl_ff[B_TX_MUTE_EN] |=> !tx_mute_out_n_o)
        else $error("transmit mute idle while dialing");
    timed_end_a: assert property (state_ff == ST_TIMED && tmr_ff == 20'h00000
        |=> done_ff ##1 dialer_irq_flag_ff && line_ctrl_ff[1:0] == 2'b00)
        else $error("timed function did not finish");
    flag_set_a: assert property (done_ff |=> dialer_irq_flag_ff)
        else $error("completion flag missed");
    flag_clear_a: assert property (wr_go && idx == IDX_IRQ_STATUS && dat_i[B_IRQ]
        && !done_ff |=> !dialer_irq_flag_ff)
        else $error("write one did not clear flag");
    hold_level_a: assert property (hold_line_out_o |-> $past(line_ctrl_ff[B_HOLD]))
        else $error("hold output without hold bit");

    pulse_done_c: cover property (state_ff == ST_GAP && tmr_ff == 20'h00000 ##1 done_ff);
    tone_done_c:  cover property (state_ff == ST_TONE ##1 state_ff == ST_GAP);
    flash_done_c: cover property (state_ff == ST_TIMED && line_ctrl_ff[B_FLASH]
        && tmr_ff == 20'h00000);

endmodule

// ---- src/tpd_pkg.sv ----
// constants for the tone and pulse dialer control block
package tpd_pkg;

    // clock and slow time base
    localparam int CLK_HZ       = 25_000_000;
    localparam int SLOW_OSC_HZ  = 32_768;
    localparam int SLOW_DIV_CYC = CLK_HZ / SLOW_OSC_HZ;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_DIAL_CFG   = 16'hff10;
    localparam logic [15:0] IDX_PAUSE_SEL  = 16'hff11;
    localparam logic [15:0] IDX_FLASH_SEL  = 16'hff12;
    localparam logic [15:0] IDX_LINE_CTRL  = 16'hff14;
    localparam logic [15:0] IDX_GAP_SEL    = 16'hff15;
    localparam logic [15:0] IDX_TONE_CTRL  = 16'hff16;
    localparam logic [15:0] IDX_DIGIT      = 16'hff17;
    localparam logic [15:0] IDX_HOOK_CTRL  = 16'hff18;
    localparam logic [15:0] IDX_PIN_SEL    = 16'hff19;
    localparam logic [15:0] IDX_IRQ_MASK   = 16'hffe9;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hfff9;

    // field positions
    localparam int B_PULSE_RATE  = 0;
    localparam int B_MAKE_RATIO  = 1;
    localparam int B_DIAL_MODE   = 3;
    localparam int B_FLASH       = 0;
    localparam int B_PAUSE       = 1;
    localparam int B_HOLD        = 2;
    localparam int B_HANDSFREE   = 3;
    localparam int B_COL_TONE    = 0;
    localparam int B_ROW_TONE    = 1;
    localparam int B_TONE_DUR    = 2;
    localparam int B_CONT_TONE   = 3;
    localparam int B_TX_MUTE_EN  = 0;
    localparam int B_RX_MUTE_EN  = 1;
    localparam int B_OFFHOOK     = 3;
    localparam int B_SEL_TX_MUTE = 0;
    localparam int B_SEL_RX_MUTE = 1;
    localparam int B_SEL_HOLD    = 2;
    localparam int B_SEL_HFREE   = 3;
    localparam int B_IRQ         = 0;

    // values after reset
    localparam logic [3:0] RST_DIAL_CFG  = 4'h0;
    localparam logic [3:0] RST_PAUSE_SEL = 4'h4;
    localparam logic [3:0] RST_FLASH_SEL = 4'h6;
    localparam logic [3:0] RST_GAP_SEL   = 4'h8;
    localparam logic [3:0] RST_TONE_CTRL = 4'h3;
    localparam logic [3:0] RST_ZERO      = 4'h0;

    // times in their own units and their counts of slow ticks (least times round up)
    localparam int TONE_LONG_MS   = 94;
    localparam int TONE_SHORT_MS  = 47;
    localparam int TONE_GAP_MS    = 94;
    localparam int SEL_STEP_US    = 93_750;
    localparam int PAUSE_STEP_S   = 1;
    localparam int PERIOD_10PPS_MS = 100;
    localparam int PERIOD_20PPS_MS = 50;
    localparam int MAKE_40_PERMIL = 400;
    localparam int MAKE_33_PERMIL = 333;
    localparam int TONE_LONG_TK   = (TONE_LONG_MS * SLOW_OSC_HZ + 999) / 1000;
    localparam int TONE_SHORT_TK  = (TONE_SHORT_MS * SLOW_OSC_HZ + 999) / 1000;
    localparam int TONE_GAP_TK    = (TONE_GAP_MS * SLOW_OSC_HZ + 999) / 1000;
    localparam int SEL_STEP_TK    = (SEL_STEP_US / 250 * SLOW_OSC_HZ) / 4000;
    localparam int PAUSE_STEP_TK  = PAUSE_STEP_S * SLOW_OSC_HZ;
    localparam int PER10_TK       = PERIOD_10PPS_MS * SLOW_OSC_HZ / 1000;
    localparam int PER20_TK       = PERIOD_20PPS_MS * SLOW_OSC_HZ / 1000;

    // decimal digit count for code zero
    localparam logic [3:0] ZERO_DIGIT_PULSES = 4'ha;

    typedef enum logic [2:0] {ST_IDLE, ST_TONE, ST_BREAK, ST_MAKE, ST_GAP, ST_TIMED}
        tpd_state_e;

endpackage

// ---- testbench/tpd_dialer_test.sv ----
// self-checking bench for the dialer control block
`timescale 1ns/100ps

module tpd_dialer_test;
    import tpd_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [17:0] adr_i = '0;
    logic [3:0]  sel_i = '0;
    logic [31:0] dat_i = '0;
    logic [31:0] dat_o;
    logic        ack_o, irq_o, line_o, txm_n, rxm_n, hold_o, hfree_o, tone_o, row_o, col_o;
    logic [3:0]  dig_o, r;
    logic [3:0]  rd_q[$];
    logic [3:0]  cfg[3] = '{4'h8, 4'hb, 4'h0};
    logic [3:0]  dig[3] = '{4'h3, 4'h2, 4'h5};
    logic [3:0]  np[3]  = '{4'h3, 4'h2, 4'h0};
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc_cnt = 0;
    int          seed = 32'h28fb;
    int          breaks, mute_cyc, b0, m0;

    tpd_dialer #(.SLOW_DIV(2)) u_tpd_dialer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .dial_pulse_out_o(line_o),
        .tx_mute_out_n_o(txm_n), .rx_mute_out_n_o(rxm_n), .hold_line_out_o(hold_o),
        .handsfree_out_o(hfree_o), .tone_active_o(tone_o), .row_tone_enable_o(row_o),
        .col_tone_enable_o(col_o), .digit_code_o(dig_o));
    tpd_line_model u_tpd_line_model (.clk_i(clk_i), .line_i(line_o), .tx_mute_n_i(txm_n),
        .breaks_o(breaks), .mute_cyc_o(mute_cyc));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; held until ack is sampled, released at that edge
    task automatic bus(input logic [15:0] idx, input logic w, input logic [3:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        sel_i <= 4'hf;
        adr_i <= {idx, 2'b00};
        dat_i <= {28'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20)
            chk(4'h0, 4'h1);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [3:0] d);
        bus(idx, 1'b1, d);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [3:0] e);
        rd_q.push_back(e);
        bus(idx, 1'b0, 4'h0);
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < 40000)
        begin
            @(posedge clk_i);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // oldest noted read value is compared when a read is acknowledged
    always @(posedge clk_i)
        if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0)
            chk(dat_o[3:0], rd_q.pop_front());
    // clock, and a cycle ceiling well above the expected run length
    initial
        forever #20 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 90000)
        begin
            err_count++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(IDX_DIAL_CFG, 4'h0);
        rd(IDX_PAUSE_SEL, 4'h4);
        rd(IDX_FLASH_SEL, 4'h6);
        rd(IDX_GAP_SEL, 4'h8);
        rd(IDX_TONE_CTRL, 4'h3);
        rd(IDX_IRQ_STATUS, 4'h0);
        rd(16'hff13, 4'h0); // unmapped hole reads zero
        chk({2'h0, row_o, col_o}, 4'h3);
        r = 4'($random(seed));
        wr(IDX_PAUSE_SEL, r);
        rd(IDX_PAUSE_SEL, r);
        wr(IDX_TONE_CTRL, 4'h7);
        rd(IDX_TONE_CTRL, 4'h7);
        wr(IDX_GAP_SEL, 4'h1);
        rd(IDX_GAP_SEL, 4'h1);
        wr(IDX_FLASH_SEL, 4'h1);
        rd(IDX_FLASH_SEL, 4'h1);
        // pins routed and line seized before anything is dialled
        wr(IDX_PIN_SEL, 4'hf);
        wr(IDX_IRQ_MASK, 4'h1);
        wr(IDX_HOOK_CTRL, 4'hb);
        repeat (2) @(posedge clk_i);
        chk({3'h0, line_o}, 4'h1);
        // pulse 10 pps, pulse 20 pps 33:66, then a short tone digit; tone clock runs
        for (int i = 0; i < 3; i++)
        begin
            wr(IDX_DIAL_CFG, cfg[i]);
            b0 = breaks;
            m0 = mute_cyc;
            wr(IDX_DIGIT, dig[i]);
            repeat (2) @(posedge clk_i);
            chk({3'h0, tone_o}, {3'h0, !cfg[i][B_DIAL_MODE]});
            chk({3'h0, rxm_n}, 4'h0);
            wait_irq();
            chk({3'h0, irq_o}, 4'h1);
            chk(dig_o, dig[i]);
            chk(4'(breaks - b0), np[i]);
            chk({3'h0, mute_cyc > m0}, 4'h1);
            wr(IDX_IRQ_STATUS, 4'h1);
            rd(IDX_IRQ_STATUS, 4'h0);
        end
        // flash opens the line and ends by itself
        wr(IDX_LINE_CTRL, 4'h1);
        repeat (2) @(posedge clk_i);
        chk({3'h0, line_o}, 4'h0);
        wait_irq();
        chk({3'h0, irq_o}, 4'h1);
        // masking hides the request but keeps the flag
        wr(IDX_IRQ_MASK, 4'h0);
        @(posedge clk_i);
        chk({3'h0, irq_o}, 4'h0);
        rd(IDX_IRQ_STATUS, 4'h1);
        wr(IDX_IRQ_STATUS, 4'h1);
        wr(IDX_IRQ_MASK, 4'h1);
        wr(IDX_LINE_CTRL, 4'hc);
        repeat (4) @(posedge clk_i);
        chk({2'h0, hold_o, hfree_o}, 4'h3);
        chk({3'h0, irq_o}, 4'h0);
        print_verdict();
    end
endmodule

// ---- testbench/tpd_line_model.sv ----
// telephone line model counting dial breaks and muted cycles
`timescale 1ns/100ps

module tpd_line_model (
    input  wire logic clk_i,
    input  wire logic line_i,
    input  wire logic tx_mute_n_i,
    output int        breaks_o,
    output int        mute_cyc_o
);
    logic line_ff = 1'b0;
    initial breaks_o = 0;
    initial mute_cyc_o = 0;
    // a break is the loop opening after it was closed; flash counts too
    always @(posedge clk_i)
    begin
        line_ff <= line_i;
        if (line_ff === 1'b1 && line_i === 1'b0)
            breaks_o <= breaks_o + 1;
        if (tx_mute_n_i === 1'b0)
            mute_cyc_o <= mute_cyc_o + 1;
    end
endmodule
